/* core/ecrs_pkg.sv */
package ecrs_pkg;
	// core clock rate and link timing
	localparam int unsigned CORE_CLK_HZ = 100_000_000;
	localparam int unsigned LINK_CLK_HZ = 8_000_000;
	localparam int unsigned OSC_CLK_HZ = 8_000_000;
	// oscillator half period in core cycles, rounded down, at least one
	localparam int unsigned OSC_HALF_CYC_RAW = CORE_CLK_HZ / (2 * OSC_CLK_HZ);
	localparam int unsigned OSC_HALF_CYC = (OSC_HALF_CYC_RAW < 1) ? 1 : OSC_HALF_CYC_RAW;
	// link clock half period in core cycles for the controller divider
	localparam int unsigned LINK_HALF_CYC_RAW = CORE_CLK_HZ / (2 * LINK_CLK_HZ);
	localparam int unsigned LINK_HALF_CYC = (LINK_HALF_CYC_RAW < 1) ? 1 : LINK_HALF_CYC_RAW;
	// startup time on the internal oscillator, in oscillator periods (rising edges)
	localparam int unsigned STARTUP_TICKS = 64;
	// missing link clock: no rising edge within this time, ns
	localparam int unsigned LOSS_TIME_NS = 1000;
	localparam int unsigned LOSS_CYC = (LOSS_TIME_NS * (CORE_CLK_HZ / 1_000_000)) / 1000;
	// i2c bus rate bounds, Hz
	localparam int unsigned I2C_MIN_HZ = 100_000;
	localparam int unsigned I2C_MAX_HZ = 400_000;
	// controller i2c rate chosen inside the bounds
	localparam int unsigned I2C_HZ = 100_000;
	localparam int unsigned I2C_HALF_CYC = CORE_CLK_HZ / (2 * I2C_HZ);
	// controller holds system reset this long after mandatory lines rise
	localparam int unsigned REL_HOLD_CYC = 16;
	localparam int unsigned CNT_W = 16;
	typedef enum logic [1:0] {ECRS_ST_STARTUP, ECRS_ST_RUN, ECRS_ST_LOST} ecrs_state_e;
endpackage : ecrs_pkg

/* core/ecrs_link_if.sv */
`timescale 1ns/1ps
interface ecrs_link_if;
	// link pins
	logic link_clock;
	logic link_write_data;
	logic link_read_data;
	// shared open-drain reset
	logic expander_reset_n_o;
	logic expander_reset_n_oe;
	logic ctrl_reset_n_o;
	logic ctrl_reset_n_oe;
	logic expander_reset_n;
	// primary clock out
	logic expander_clock_out;
	logic expander_clock_out_oe;
	// i2c
	logic scl_o;
	logic scl_oe;
	logic sda_o;
	logic sda_oe;
	logic sda_dev_oe;
	logic scl;
	logic sda;
	assign expander_reset_n = !(expander_reset_n_oe && !expander_reset_n_o)
		&& !(ctrl_reset_n_oe && !ctrl_reset_n_o);
	assign scl = !(scl_oe && !scl_o);
	assign sda = !(sda_oe && !sda_o) && !sda_dev_oe;
	modport device (
		input link_clock,
		input link_write_data,
		output link_read_data,
		output expander_reset_n_o,
		output expander_reset_n_oe,
		input expander_reset_n,
		output expander_clock_out,
		output expander_clock_out_oe,
		input scl,
		input sda,
		output sda_dev_oe
	);
	modport ctrl (
		output link_clock,
		output link_write_data,
		input link_read_data,
		output ctrl_reset_n_o,
		output ctrl_reset_n_oe,
		input expander_reset_n,
		input expander_clock_out,
		input expander_clock_out_oe,
		output scl_o,
		output scl_oe,
		output sda_o,
		output sda_oe,
		input scl,
		input sda
	);
endinterface : ecrs_link_if

/* core/ecrs_expander.sv */
`timescale 1ns/1ps
// Functional notes
// RULE1 - startup runs from internal 8 MHz oscillator
// RULE2 - after startup, run on link_clock
// RULE3 - controller drives link_clock to every expander
// RULE4 - detect link_clock loss, self reset, pull reset
// RULE5 - after loss, digital outputs go safe
// RULE6 - primary drives oscillator on expander_clock_out
// RULE7 - non-primary expanders disable expander_clock_out
// RULE8 - external clock source: primary also disables it
// RULE9 - nobody else drives expander_reset_n; the controller pulls it low during soft_reset
// RULE10 - controller holds reset while mandatory missing
// RULE11 - faulted mandatory expander holds reset low
// RULE12 - controller treats primary as mandatory, monitors it
// RULE13 - optional reset clears only its own state
// RULE14 - link has three wires, 8 MHz, checking
// RULE15 - one dedicated link per expander
// RULE16 - i2c runs between 100 and 400 kHz
// RULE17 - controller syncs reset, releases after all mandatory
module ecrs_expander import ecrs_pkg::*; #(
	parameter bit IS_PRIMARY = 1'b1,
	parameter bit EXT_CLK_SRC = 1'b0,
	parameter int unsigned LOSS_LIMIT = LOSS_CYC
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	// link side
	ecrs_link_if.device lnk,
	// user side
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic link_err,
	output logic running,
	output logic safe_state
);
	logic [1:0] lclk_sync_r;
	logic [1:0] link_write_data_sync_r;
	logic lclk_d_r;
	logic [CNT_W-1:0] osc_cnt_r;
	logic osc_clk_r;
	logic [CNT_W-1:0] start_cnt_r;
	logic [CNT_W-1:0] loss_cnt_r;
	ecrs_state_e state_r;
	logic [8:0] rx_sh_r;
	logic [3:0] rx_bits_r;
	logic [8:0] tx_sh_r;
	logic [3:0] tx_bits_r;
	logic [7:0] rx_byte_r;
	logic rx_valid_r;
	logic link_err_r;
	logic link_read_data_r;
	logic clkout_en_r;

	// synchronised link inputs
	wire lclk_s = lclk_sync_r[1];
	wire link_write_data_s = link_write_data_sync_r[1];
	wire lclk_rise = lclk_s && !lclk_d_r;
	wire osc_tick = (osc_cnt_r == CNT_W'(OSC_HALF_CYC - 1));
	wire osc_rise = osc_tick && !osc_clk_r;
	wire start_done = (start_cnt_r == CNT_W'(STARTUP_TICKS));
	wire loss_hit = (loss_cnt_r >= CNT_W'(LOSS_LIMIT));
	wire is_run = (state_r == ECRS_ST_RUN);
	wire rx_full = (rx_bits_r == 4'h8);
	// frame decode: eight data bits, odd parity last
	wire [8:0] rx_frame = {rx_sh_r[7:0], link_write_data_s};
	wire rx_par_bad = ~^rx_frame;
	wire [8:0] tx_load = {tx_byte, ~^tx_byte};

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			lclk_sync_r <= 2'h0;
			link_write_data_sync_r <= 2'h0;
			lclk_d_r <= 1'b0;
		end else if (clk_en) begin
			lclk_sync_r <= {lclk_sync_r[0], lnk.link_clock};
			link_write_data_sync_r <= {link_write_data_sync_r[0], lnk.link_write_data};
			lclk_d_r <= lclk_s;
		end
	end

	// shared reset and i2c pins, watched only
	// two flip-flops per pin before any use
	wire [2:0] pin_raw = {lnk.expander_reset_n, lnk.scl, lnk.sda};
	logic [2:0] pin_s;
	for (genvar gi = 0; gi < 3; gi++) begin : g_pin_sync
		logic [1:0] sync_r;
		always_ff @(posedge core_clk or posedge reset) begin
			if (reset) begin
				sync_r <= 2'h3;
			end else if (clk_en) begin
				sync_r <= {sync_r[0], pin_raw[gi]};
			end
		end
		assign pin_s[gi] = sync_r[1];
	end

	// internal oscillator model, divided from the core clock
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			osc_cnt_r <= '0;
			osc_clk_r <= 1'b0;
		end else if (clk_en) begin
			osc_cnt_r <= osc_tick ? '0 : osc_cnt_r + 1'b1; // see RULE1
			if (osc_tick)
				osc_clk_r <= !osc_clk_r;
		end
	end

	// startup on oscillator, then switch, then loss watch
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_r <= ECRS_ST_STARTUP;
			start_cnt_r <= '0;
			loss_cnt_r <= '0;
		end else if (clk_en) begin
			case (state_r)
				ECRS_ST_STARTUP: begin
					loss_cnt_r <= '0;
					if (osc_rise && !start_done)
						start_cnt_r <= start_cnt_r + 1'b1; // see RULE1
					if (start_done && lclk_rise)
						state_r <= ECRS_ST_RUN; // see RULE2
				end
				ECRS_ST_RUN: begin
					loss_cnt_r <= lclk_rise ? '0 : loss_cnt_r + 1'b1;
					if (loss_hit)
						state_r <= ECRS_ST_LOST; // see RULE4
				end
				ECRS_ST_LOST: begin
					// self reset: restart startup from the oscillator
					start_cnt_r <= '0; // see RULE4
					loss_cnt_r <= '0;
					state_r <= ECRS_ST_STARTUP;
				end
				default: state_r <= ECRS_ST_STARTUP;
			endcase
		end
	end

	// link data path, sampled on link_clock rising edges; odd parity bit last
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rx_sh_r <= '0;
			rx_bits_r <= '0;
			rx_byte_r <= 8'h00;
			rx_valid_r <= 1'b0;
			link_err_r <= 1'b0;
			tx_sh_r <= '0;
			tx_bits_r <= '0;
			link_read_data_r <= 1'b0;
		end else if (clk_en) begin
			rx_valid_r <= 1'b0;
			if (!is_run) begin
				rx_bits_r <= '0; // see RULE5
				tx_bits_r <= '0;
				link_read_data_r <= 1'b0;
				rx_byte_r <= 8'h00;
				link_err_r <= 1'b0;
			end else if (lclk_rise) begin
				rx_sh_r <= {rx_sh_r[7:0], link_write_data_s}; // see RULE14
				if (rx_full) begin
					rx_bits_r <= '0;
					rx_byte_r <= rx_sh_r[7:0];
					rx_valid_r <= 1'b1;
					link_err_r <= rx_par_bad; // see RULE14
				end else begin
					rx_bits_r <= rx_bits_r + 1'b1;
				end
				if (tx_bits_r == 4'h0) begin
					tx_sh_r <= tx_load;
					link_read_data_r <= tx_byte[7];
					tx_bits_r <= 4'h8;
				end else begin
					tx_sh_r <= {tx_sh_r[7:0], 1'b0};
					link_read_data_r <= tx_sh_r[7];
					tx_bits_r <= tx_bits_r - 1'b1;
				end
			end
		end
	end

	// clock out enable only for the primary on its own oscillator
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			clkout_en_r <= 1'b0;
		else if (clk_en)
			clkout_en_r <= IS_PRIMARY && !EXT_CLK_SRC; // see RULE6, RULE7, RULE8
	end

	assign lnk.link_read_data = link_read_data_r;
	assign lnk.expander_clock_out = clkout_en_r && osc_clk_r; // see RULE6
	assign lnk.expander_clock_out_oe = clkout_en_r; // see RULE7
	// open-drain reset: pulled low until running; link clock loss pulls it low again
	assign lnk.expander_reset_n_o = 1'b0;
	assign lnk.expander_reset_n_oe = !is_run; // see RULE4, RULE11
	assign lnk.sda_dev_oe = 1'b0;
	assign rx_byte = rx_byte_r;
	assign rx_valid = rx_valid_r;
	assign link_err = link_err_r;
	assign running = is_run;
	assign safe_state = !is_run; // see RULE5
	// pins kept for the i2c slave, only watched here
	logic unused_ok;
	assign unused_ok = ^pin_s;
endmodule : ecrs_expander

/* core/ecrs_controller.sv */
`timescale 1ns/1ps
module ecrs_controller import ecrs_pkg::*; #(
	parameter bit IS_MANDATORY = 1'b1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	input wire logic clk_en,
	// link side, one dedicated instance per expander
	ecrs_link_if.ctrl lnk, // see RULE15
	// user side
	input wire logic soft_reset,
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output logic rx_valid,
	output logic link_err,
	output logic system_reset,
	output logic expander_reset
);
	logic [CNT_W-1:0] div_cnt_r;
	logic lclk_r;
	logic [1:0] rst_sync_r;
	logic [1:0] link_read_data_sync_r;
	logic [CNT_W-1:0] rel_cnt_r;
	logic sys_rst_r;
	logic [8:0] tx_sh_r;
	logic [3:0] tx_bits_r;
	logic link_write_data_r;
	logic [8:0] rx_sh_r;
	logic [3:0] rx_bits_r;
	logic [7:0] rx_byte_r;
	logic rx_valid_r;
	logic link_err_r;
	logic rx_arm_r;
	logic [CNT_W-1:0] i2c_cnt_r;
	logic scl_r;

	wire div_tick = (div_cnt_r == CNT_W'(LINK_HALF_CYC - 1));
	wire lclk_rise = div_tick && !lclk_r;
	wire lclk_fall = div_tick && lclk_r;
	wire rst_line = rst_sync_r[1];
	wire rel_done = (rel_cnt_r == CNT_W'(REL_HOLD_CYC));
	wire i2c_tick = (i2c_cnt_r == CNT_W'(I2C_HALF_CYC - 1));

	// link clock divider, always running to every expander
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			div_cnt_r <= '0;
			lclk_r <= 1'b0;
		end else if (clk_en) begin
			div_cnt_r <= div_tick ? '0 : div_cnt_r + 1'b1; // see RULE3
			if (div_tick)
				lclk_r <= !lclk_r;
		end
	end

	// shared reset watch: synchronise, release after all mandatory let go
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rst_sync_r <= 2'h0;
			link_read_data_sync_r <= 2'h0;
			rel_cnt_r <= '0;
			sys_rst_r <= 1'b1;
		end else if (clk_en) begin
			rst_sync_r <= {rst_sync_r[0], lnk.expander_reset_n}; // see RULE17
			link_read_data_sync_r <= {link_read_data_sync_r[0], lnk.link_read_data};
			if (!rst_line || soft_reset) begin
				rel_cnt_r <= '0; // see RULE10, RULE12
				sys_rst_r <= 1'b1;
			end else if (!rel_done) begin
				rel_cnt_r <= rel_cnt_r + 1'b1;
			end else begin
				sys_rst_r <= 1'b0; // see RULE17
			end
		end
	end

	// link data; write on falling edge, sample read on rising edge
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			tx_sh_r <= '0;
			tx_bits_r <= '0;
			link_write_data_r <= 1'b0;
			rx_sh_r <= '0;
			rx_bits_r <= '0;
			rx_byte_r <= 8'h00;
			rx_valid_r <= 1'b0;
			link_err_r <= 1'b0;
			rx_arm_r <= 1'b0;
		end else if (clk_en) begin
			rx_valid_r <= 1'b0;
			if (!rst_line) begin
				// optional expander reset clears only this link's state
				tx_bits_r <= '0; // see RULE13
				rx_bits_r <= '0;
				rx_arm_r <= 1'b0;
				// data line only moves while link_clock is low
				if (lclk_fall)
					link_write_data_r <= 1'b0;
				rx_byte_r <= 8'h00;
				link_err_r <= 1'b0;
			end else begin
				if (lclk_fall) begin
					if (tx_bits_r == 4'h0) begin
						tx_sh_r <= {tx_byte, ~^tx_byte}; // see RULE14
						link_write_data_r <= tx_byte[7];
						tx_bits_r <= 4'h8;
					end else begin
						tx_sh_r <= {tx_sh_r[7:0], 1'b0};
						link_write_data_r <= tx_sh_r[7];
						tx_bits_r <= tx_bits_r - 1'b1;
					end
				end
				if (lclk_rise && !rx_arm_r) begin
					// expander's first bit comes one link_clock later
					rx_arm_r <= 1'b1;
				end else if (lclk_rise) begin
					rx_sh_r <= {rx_sh_r[7:0], link_read_data_sync_r[1]};
					if (rx_bits_r == 4'h8) begin
						rx_bits_r <= '0;
						rx_byte_r <= rx_sh_r[7:0];
						rx_valid_r <= 1'b1;
						link_err_r <= (^{rx_sh_r[7:0], link_read_data_sync_r[1]}) == 1'b0; // see RULE14
					end else begin
						rx_bits_r <= rx_bits_r + 1'b1;
					end
				end
			end
		end
	end

	// i2c clock starts high, holds its level during system reset, toggles at the chosen bus rate
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			i2c_cnt_r <= '0;
			scl_r <= 1'b1;
		end else if (clk_en) begin
			i2c_cnt_r <= i2c_tick ? '0 : i2c_cnt_r + 1'b1; // see RULE16
			if (i2c_tick && !sys_rst_r)
				scl_r <= !scl_r;
		end
	end

	assign lnk.link_clock = lclk_r;
	assign lnk.link_write_data = link_write_data_r;
	// controller only pulls the shared line for a soft reset
	assign lnk.ctrl_reset_n_o = 1'b0;
	assign lnk.ctrl_reset_n_oe = soft_reset; // see RULE9
	assign lnk.scl_o = 1'b0;
	assign lnk.scl_oe = !scl_r;
	assign lnk.sda_o = 1'b0;
	assign lnk.sda_oe = 1'b0;
	assign rx_byte = rx_byte_r;
	assign rx_valid = rx_valid_r;
	assign link_err = link_err_r;
	assign system_reset = IS_MANDATORY ? sys_rst_r : 1'b0; // see RULE10
	assign expander_reset = !rst_line;
endmodule : ecrs_controller

/* dv/ecrs_chk_asserts.sv */
`timescale 1ns/1ps
module ecrs_chk_asserts (
	// clock and reset
	input wire logic core_clk,
	input wire logic reset,
	// link and shared lines
	input wire logic link_clock,
	input wire logic link_write_data,
	input wire logic expander_reset_n_oe,
	input wire logic expander_reset_n,
	input wire logic expander_clock_out,
	input wire logic expander_clock_out_oe,
	input wire logic scl
);
	logic [15:0] idle_r;
	logic [15:0] low_r;
	logic [15:0] scl_r;
	logic [3:0] since_r;
	logic lclk_q_r;
	logic scl_q_r;
	// cycle counters since last change; since_r counts from reset and saturates
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			idle_r <= 16'h0000;
			low_r <= 16'h0000;
			scl_r <= 16'h0000;
			since_r <= 4'h0;
			lclk_q_r <= 1'b0;
			scl_q_r <= 1'b1;
		end else begin
			lclk_q_r <= link_clock;
			scl_q_r <= scl;
			idle_r <= (link_clock != lclk_q_r) ? 16'h0000 : idle_r + 16'h0001;
			low_r <= expander_reset_n_oe ? low_r + 16'h0001 : 16'h0000;
			scl_r <= (scl != scl_q_r) ? 16'h0000 : scl_r + 16'h0001;
			since_r <= (since_r == 4'hF) ? since_r : since_r + 4'h1;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	sequence s_high_hold;
		link_clock [*5];
	endsequence
	AST_CLKOUT_EN: assert property (since_r == 4'hF |-> expander_clock_out_oe)
		else $error("primary clock out not enabled");
	AST_CLKOUT_TOG: assert property (expander_clock_out_oe |-> ##[1:7] $changed(expander_clock_out))
		else $error("clock out not toggling");
	AST_LOSS_RESET: assert property (idle_r == 16'h0078 |-> expander_reset_n_oe && !expander_reset_n)
		else $error("reset line not pulled on link clock loss");
	AST_LINK_HALF: assert property ($rose(link_clock) |-> ##1 s_high_hold)
		else $error("link clock high phase too short");
	AST_LINK_WRITE_DATA_FALL: assert property ($changed(link_write_data) |-> !link_clock)
		else $error("write data changed while link clock high");
	AST_RELEASE_EDGE: assert property ($fell(expander_reset_n_oe) |-> idle_r < 16'h0014)
		else $error("reset released without link clock");
	AST_STARTUP_LEN: assert property ($fell(expander_reset_n_oe) |-> low_r >= 16'h02BC)
		else $error("startup too short");
	AST_SCL_RATE: assert property ($changed(scl) && since_r == 4'hF |-> scl_r >= 16'h0078)
		else $error("i2c clock too fast");
endmodule : ecrs_chk_asserts

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench import ecrs_pkg::*;;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic ctl_en = 1'b1;
	logic [7:0] ctl_tx = 8'h00;
	logic [7:0] exp_tx = 8'h00;
	logic [7:0] c_rx;
	logic [7:0] e_rx;
	logic c_rv, e_rv, c_err, e_err, sys_rst, exp_rst, e_run, e_safe;
	int num_errors = 0;
	int n_tests = 0;
	int n_erx = 0;
	int n_crx = 0;
	logic ctl_soft = 1'b0;
	ecrs_link_if lnk ();
	// both ends
	ecrs_controller ecrs_controller_inst (.core_clk(core_clk), .reset(reset), .clk_en(ctl_en),
		.lnk(lnk.ctrl), .soft_reset(ctl_soft), .tx_byte(ctl_tx), .rx_byte(c_rx), .rx_valid(c_rv),
		.link_err(c_err), .system_reset(sys_rst), .expander_reset(exp_rst));
	ecrs_expander ecrs_expander_inst (.core_clk(core_clk), .reset(reset), .clk_en(1'b1),
		.lnk(lnk.device), .tx_byte(exp_tx), .rx_byte(e_rx), .rx_valid(e_rv),
		.link_err(e_err), .running(e_run), .safe_state(e_safe));
	ecrs_chk_asserts ecrs_chk_asserts_inst (.core_clk(core_clk), .reset(reset),
		.link_clock(lnk.link_clock), .link_write_data(lnk.link_write_data),
		.expander_reset_n_oe(lnk.expander_reset_n_oe), .expander_reset_n(lnk.expander_reset_n),
		.expander_clock_out(lnk.expander_clock_out),
		.expander_clock_out_oe(lnk.expander_clock_out_oe), .scl(lnk.scl));
	always #5 core_clk = ~core_clk;
	always @(posedge core_clk) if (e_rv === 1'b1) n_erx <= n_erx + 1;
	always @(posedge core_clk) if (c_rv === 1'b1) n_crx <= n_crx + 1;
	function automatic int startup_cyc();
		return 64 * 2 * OSC_HALF_CYC;
	endfunction : startup_cyc
	function automatic int min_bytes(int cyc_n);
		return cyc_n / (18 * LINK_HALF_CYC) - 2;
	endfunction : min_bytes
	task automatic chk(logic got, logic exp, string msg);
		n_tests++;
		if (got !== exp) begin
			$display("CHECK FAILED %0t %s", $time, msg);
			num_errors++;
		end
	endtask : chk
	task automatic cyc(int n);
		repeat (n) @(posedge core_clk);
	endtask : cyc
	task automatic wait_run();
		for (int i = 0; i < 4000 && e_run !== 1'b1; i++) cyc(1);
		cyc(40);
		#1;
		chk(e_run, 1'b1, "expander not running");
		chk(e_safe, 1'b0, "expander still in safe state");
		chk(sys_rst, 1'b0, "system reset not released");
		chk(lnk.expander_clock_out_oe, 1'b1, "primary clock out disabled");
		chk(exp_rst, 1'b0, "expander reset still seen");
	endtask : wait_run
	task automatic startup_test();
		reset <= 1'b1;
		cyc(2);
		reset <= 1'b0;
		cyc(startup_cyc() - 100);
		#1;
		chk(e_run, 1'b0, "expander ran before startup ended");
		chk(lnk.expander_reset_n, 1'b0, "reset line released early");
		chk(sys_rst, 1'b1, "system left reset early");
		wait_run();
		$display("startup test done");
	endtask : startup_test
	task automatic traffic_test();
		int n0;
		int m0;
		n0 = n_erx;
		m0 = n_crx;
		for (int i = 0; i < 40; i++) begin
			ctl_tx <= (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
			exp_tx <= (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
			cyc(3 * 18 * LINK_HALF_CYC);
			#1;
			chk(e_rx == ctl_tx, 1'b1, "expander byte mismatch");
			chk(c_rx == exp_tx, 1'b1, "controller byte mismatch");
			chk(e_err, 1'b0, "parity error at expander");
			chk(c_err, 1'b0, "parity error at controller");
		end
		chk(n_erx - n0 >= min_bytes(120 * 18 * LINK_HALF_CYC), 1'b1, "too few bytes");
		chk(n_crx - m0 >= min_bytes(120 * 18 * LINK_HALF_CYC), 1'b1, "too few read bytes");
		$display("traffic test done");
	endtask : traffic_test
	task automatic soft_test();
		ctl_soft <= 1'b1;
		cyc(10);
		#1;
		chk(lnk.expander_reset_n, 1'b0, "soft reset did not pull the line");
		chk(sys_rst, 1'b1, "system not reset by soft reset");
		chk(exp_rst, 1'b1, "expander reset not seen");
		chk(e_run, 1'b1, "expander disturbed by soft reset");
		ctl_soft <= 1'b0;
		cyc(40);
		#1;
		chk(sys_rst, 1'b0, "system reset kept after soft reset");
		$display("soft reset test done");
	endtask : soft_test
	task automatic loss_test();
		ctl_en <= 1'b0;
		cyc(LOSS_CYC + 40);
		#1;
		chk(e_run, 1'b0, "still running after link clock loss");
		chk(e_safe, 1'b1, "outputs not safe after loss");
		chk(lnk.expander_reset_n, 1'b0, "reset line not held low");
		ctl_en <= 1'b1;
		cyc(20);
		#1;
		chk(sys_rst, 1'b1, "system not held in reset");
		chk(exp_rst, 1'b1, "controller did not see the line low");
		wait_run();
		$display("loss test done");
	endtask : loss_test
	task automatic close_out();
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : close_out
	initial begin
		cyc(40000);
		num_errors++;
		close_out();
	end
	initial begin
		void'($urandom(73));
		startup_test();
		traffic_test();
		soft_test();
		loss_test();
		startup_test();
		close_out();
	end
endmodule : testbench
